// [logic/sleep_gate_pkg.sv]
package sleep_gate_pkg;

  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam logic [11:0] OFF_RUN_GATE    = 12'h100;
  localparam logic [11:0] OFF_SLEEP_GATE  = 12'h110;
  localparam logic [11:0] OFF_DSLEEP_GATE = 12'h120;
  localparam logic [11:0] OFF_RUN_CFG     = 12'h060;

  localparam logic [31:0] GATE_RESET      = 32'h0000_0040;
  localparam logic [31:0] GATE_WMASK      = 32'h0111_0348;
  localparam logic [31:0] RUN_CFG_RESET   = 32'h0000_0000;
  localparam int          BIT_AUTO_GATE   = 27;
  localparam logic [31:0] RUN_CFG_WMASK   = 32'h0800_0000;

  localparam int          BIT_FIELDBUS    = 24;
  localparam int          BIT_PWM         = 20;
  localparam int          BIT_CONV        = 16;
  localparam int          RATE_LO         = 8;
  localparam int          RATE_HI         = 9;
  localparam int          BIT_HIB         = 6;
  localparam int          BIT_WDOG        = 3;

  localparam logic [1:0]  RATE_1M         = 2'h3;
  localparam logic [1:0]  RATE_500K       = 2'h2;
  localparam logic [1:0]  RATE_250K       = 2'h1;
  localparam logic [1:0]  RATE_125K       = 2'h0;

  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEPSLEEP} power_mode_t;

  typedef struct packed {
    logic       fieldbus;
    logic       pwm;
    logic       conv;
    logic       hibernate_gate;
    logic       wdog;
    logic [1:0] conv_rate;
  } unit_clk_t;

endpackage : sleep_gate_pkg

// [logic/sleep_mode_clock_gating.sv]
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module sleep_mode_clock_gating (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic [11:0]             i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  input  wire sleep_gate_pkg::power_mode_t i_mode,
  input  wire logic [4:0]              i_unit_access,
  output sleep_gate_pkg::unit_clk_t    o_unit_clk,
  output logic                         o_bus_fault
);

  logic [31:0] run_gate_r;
  logic [31:0] sleep_gate_r;
  logic [31:0] dsleep_gate_r;
  logic [31:0] run_cfg_r;
  logic [31:0] rdata_r;
  logic        fault_r;
  logic [31:0] active_gate;
  logic [31:0] rdata_nxt;
  logic [4:0]  gate_vec;
  logic        fault_nxt;
  sleep_gate_pkg::unit_clk_t unit_clk_r;
  sleep_gate_pkg::unit_clk_t unit_clk_nxt;

  wire sel_run    = (i_addr == sleep_gate_pkg::OFF_RUN_GATE);
  wire sel_sleep  = (i_addr == sleep_gate_pkg::OFF_SLEEP_GATE);
  wire sel_dsleep = (i_addr == sleep_gate_pkg::OFF_DSLEEP_GATE);
  wire sel_cfg    = (i_addr == sleep_gate_pkg::OFF_RUN_CFG);
  wire auto_gate  = run_cfg_r[sleep_gate_pkg::BIT_AUTO_GATE];

  // Masked writes keep reserved and spare positions at zero.
  function automatic logic [31:0] merge(input logic [31:0] d, input logic [31:0] m);
    merge = d & m;
  endfunction : merge

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_gate_r    <= sleep_gate_pkg::GATE_RESET;
      sleep_gate_r  <= sleep_gate_pkg::GATE_RESET;
      dsleep_gate_r <= sleep_gate_pkg::GATE_RESET;
      run_cfg_r     <= sleep_gate_pkg::RUN_CFG_RESET;
    end else if (i_wr) begin
      if (sel_run)
        run_gate_r <= merge(i_wdata, sleep_gate_pkg::GATE_WMASK);
      if (sel_sleep)
        sleep_gate_r <= merge(i_wdata, sleep_gate_pkg::GATE_WMASK);
      if (sel_dsleep)
        dsleep_gate_r <= merge(i_wdata, sleep_gate_pkg::GATE_WMASK);
      if (sel_cfg)
        run_cfg_r <= merge(i_wdata, sleep_gate_pkg::RUN_CFG_WMASK);
    end
  end

  // Without automatic gating the run set stays in force through every low-power mode.
  assign active_gate =
    (i_mode == sleep_gate_pkg::MODE_SLEEP && auto_gate)     ? sleep_gate_r  :
    (i_mode == sleep_gate_pkg::MODE_DEEPSLEEP && auto_gate) ? dsleep_gate_r :
    run_gate_r;

  assign unit_clk_nxt.fieldbus  = active_gate[sleep_gate_pkg::BIT_FIELDBUS];
  assign unit_clk_nxt.pwm       = active_gate[sleep_gate_pkg::BIT_PWM];
  assign unit_clk_nxt.conv      = active_gate[sleep_gate_pkg::BIT_CONV];
  assign unit_clk_nxt.hibernate_gate       = active_gate[sleep_gate_pkg::BIT_HIB];
  assign unit_clk_nxt.wdog      = active_gate[sleep_gate_pkg::BIT_WDOG];
  assign unit_clk_nxt.conv_rate = active_gate[sleep_gate_pkg::RATE_HI:sleep_gate_pkg::RATE_LO];

  assign gate_vec  = {unit_clk_nxt.fieldbus, unit_clk_nxt.pwm, unit_clk_nxt.conv,
                      unit_clk_nxt.hibernate_gate, unit_clk_nxt.wdog};
  assign fault_nxt = |(i_unit_access & ~gate_vec);

  assign rdata_nxt =
    sel_run    ? run_gate_r    :
    sel_sleep  ? sleep_gate_r  :
    sel_dsleep ? dsleep_gate_r :
    sel_cfg    ? run_cfg_r     :
    32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_r    <= 32'h0000_0000;
      fault_r    <= 1'b0;
      unit_clk_r <= '0;
    end else begin
      rdata_r    <= i_rd ? rdata_nxt : 32'h0000_0000;
      fault_r    <= fault_nxt;
      unit_clk_r <= unit_clk_nxt;
    end
  end

  assign o_rdata     = rdata_r;
  assign o_bus_fault = fault_r;
  assign o_unit_clk  = unit_clk_r;

endmodule : sleep_mode_clock_gating

// [tb/gate_props.sv]
`timescale 1ns/1ps
module gate_props (
  input wire logic                        i_clk,
  input wire logic                        i_rst,
  input wire logic [11:0]                 i_addr,
  input wire logic                        i_rd,
  input wire logic                        i_wr,
  input wire logic [31:0]                 o_rdata,
  input wire sleep_gate_pkg::power_mode_t i_mode,
  input wire logic [4:0]                  i_unit_access,
  input wire sleep_gate_pkg::unit_clk_t   o_unit_clk,
  input wire logic                        o_bus_fault
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rd idle");
  rsv_zero_a: assert property (o_rdata[31:25] == 7'h00) else $error("rsv bits");
  gate_mask_a: assert property ($past(i_rd && i_addr == 12'h110) |->
    (o_rdata & ~sleep_gate_pkg::GATE_WMASK) == 32'h0) else $error("gate mask");
  fault_none_a: assert property (i_unit_access == 5'h00 |=> !o_bus_fault) else $error("f0");
  fault_wdog_a: assert property (i_unit_access == 5'h01 |=>
    o_bus_fault != o_unit_clk.wdog) else $error("wdog fault");
  fault_can_a: assert property (i_unit_access == 5'h10 |=>
    o_bus_fault != o_unit_clk.fieldbus) else $error("fb fault");
  clk_hold_a: assert property (!$past(i_rst) && !$past(i_wr) && $stable(i_mode) |=>
    $stable(o_unit_clk)) else $error("clk moved");
endmodule : gate_props

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  logic                        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [11:0]                 i_addr = 12'h000;
  logic [31:0]                 i_wdata = 32'h0, o_rdata;
  sleep_gate_pkg::power_mode_t i_mode = sleep_gate_pkg::MODE_RUN;
  logic [4:0]                  i_unit_access = 5'h00;
  sleep_gate_pkg::unit_clk_t   o_unit_clk;
  logic                        o_bus_fault;
  int                          miscompares = 0, tests_run = 0;
  always #5 i_clk = ~i_clk;
  sleep_mode_clock_gating i_sleep_mode_clock_gating (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_mode(i_mode), .i_unit_access(i_unit_access), .o_unit_clk(o_unit_clk),
    .o_bus_fault(o_bus_fault));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_clk) i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clk) {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_clk) i_rd <= 1'b0;
    #1 chk("rdata", o_rdata, e);
  endtask : rd
  task ck(input logic [6:0] e);
    @(posedge i_clk);
    #1 chk("unit_clk", 32'(o_unit_clk), 32'(e));
  endtask : ck
  task t_regs;
    rd(12'h110, 32'h0000_0040);
    rd(12'h100, 32'h0000_0040);
    wr(12'h110, 32'hffff_ffff);
    rd(12'h110, 32'h0111_0348);
    rd(12'h200, 32'h0);
  endtask : t_regs
  task t_sleep;
    wr(12'h060, 32'h0800_0000);
    @(posedge i_clk) i_mode <= sleep_gate_pkg::MODE_SLEEP;
    wr(12'h110, 32'h0100_0000);
    ck(7'h40);
    wr(12'h110, 32'h0011_0000);
    ck(7'h30);
    @(posedge i_clk) i_mode <= sleep_gate_pkg::MODE_DEEPSLEEP;
    ck(7'h08);
    @(posedge i_clk) i_mode <= sleep_gate_pkg::MODE_SLEEP;
    for (int r = 0; r < 4; r++) begin
      wr(12'h110, 32'(r) << 8);
      ck(7'(r));
    end
  endtask : t_sleep
  task t_fault;
    @(posedge i_clk) i_unit_access <= 5'h01;
    @(posedge i_clk);
    #1 chk("fault", 32'(o_bus_fault), 32'h1);
    wr(12'h110, 32'h0000_0008);
    ck(7'h04);
    chk("fault", 32'(o_bus_fault), 32'h0);
    @(posedge i_clk) i_unit_access <= 5'h10;
    wr(12'h060, 32'h0);
    ck(7'h08);
    chk("fault", 32'(o_bus_fault), 32'h1);
  endtask : t_fault
  task results;
    $display("tests %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs;
    t_sleep;
    t_fault;
    results;
  end
  // The run needs well under a thousand cycles, so this margin only trips on a hang.
  initial begin
    #20000;
    miscompares++;
    results;
  end
endmodule : tb
bind sleep_mode_clock_gating gate_props i_gate_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .o_rdata(o_rdata), .i_mode(i_mode),
  .i_unit_access(i_unit_access), .o_unit_clk(o_unit_clk), .o_bus_fault(o_bus_fault));
